// ---- tb/dmach_periph.sv ----
// Peripheral master model on the flow-control request bus
`timescale 1ns/1ns
module dmach_periph
(
    input  wire logic [127:0] ack_i,
    input  wire logic         clk_i,
    input  wire logic [6:0]   sel_i,
    input  wire logic         go_i,
    input  wire logic         term_i,
    output logic [127:0]      req_o,
    output logic [127:0]      term_o
);
    logic [127:0] hot;
    logic [127:0] noise;
    logic [127:0] req_q;
    assign hot = 128'h1 << sel_i;
    // Request drops with the acknowledge: the channel re-samples it the very next edge
    assign req_o = req_q & ~ack_i;
    initial
    begin
        req_q = '0;
        term_o = '0;
    end
    // Other masters chatter every cycle, so a wrong slot choice shows
    always @(posedge clk_i)
    begin
        noise = {$urandom, $urandom, $urandom, $urandom};
        req_q <= (noise & ~hot) | ((go_i && (ack_i & hot) == '0) ? hot : '0);
        term_o <= (~noise & ~hot) | (term_i ? hot : '0);
    end
endmodule

// ---- tb/dmach_props.sv ----
// Checker: port-level timing of the DMA channel
`timescale 1ns/1ns
module dmach_props
(
    input wire logic                     clk_i,
    input wire logic                     rst_n_i,
    input wire dmach_pkg::dmach_apb_req_t  apb_i,
    input wire dmach_pkg::dmach_apb_rsp_t  apb_o,
    input wire logic [127:0]             fc_req_i,
    input wire logic [127:0]             fc_term_i,
    input wire logic [127:0]             fc_ack_o,
    input wire dmach_pkg::dmach_ibus_req_t ibus_o,
    input wire dmach_pkg::dmach_ibus_rsp_t ibus_i,
    input wire logic                     irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_ack_onehot:
    assert property (fc_ack_o != '0 |-> $onehot(fc_ack_o) ##1 fc_ack_o == '0)
        else $error("packet acknowledge not a single one-cycle slot");
    chk_ack_after_write:
    assert property (fc_ack_o != '0 |-> $past(ibus_i.ack && ibus_o.req && ibus_o.we, 2))
        else $error("packet acknowledge without a finished write");
    chk_bus_hold:
    assert property (ibus_o.req && !ibus_i.ack |=> ibus_o.req && $stable(ibus_o))
        else $error("internal bus request changed before its answer");
    chk_write_copy:
    assert property ($rose(ibus_o.we) |-> ibus_o.req && $past(ibus_i.ack) && ibus_o.wdata == $past(ibus_i.rdata))
        else $error("written word differs from the word read");
    chk_fault_stop:
    assert property (ibus_i.ack && ibus_i.err |=> !ibus_o.req ##1 fc_ack_o == '0)
        else $error("channel went on after a bus error");
    chk_reset_quiet:
    assert property ($past(!rst_n_i) |-> !irq_o && !apb_o.pready && ibus_o == '0 && fc_ack_o == '0)
        else $error("outputs not quiet after reset");
    chk_mask_off:
    assert property (apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite
        && apb_i.paddr == dmach_pkg::OFF_MASK && apb_i.pwdata[2:0] == 3'h0 |=> ##1 !irq_o)
        else $error("interrupt stayed up with every source masked");
    chk_ready_pulse:
    assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready ##1 !apb_o.pready)
        else $error("register access not answered in one cycle");
endmodule

bind dmach_top dmach_props dmach_props_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
    .fc_req_i(fc_req_i), .fc_term_i(fc_term_i), .fc_ack_o(fc_ack_o), .ibus_o(ibus_o), .ibus_i(ibus_i),
    .irq_o(irq_o));

// ---- tb/dmach_tb.sv ----
// Testbench: register, transfer and interrupt checks of the DMA channel
`timescale 1ns/1ns
module dmach_tb;
    logic                       clk_i = 1'b0;
    logic                       rst_n_i = 1'b0;
    dmach_pkg::dmach_apb_req_t  apb_i = '0;
    dmach_pkg::dmach_apb_rsp_t  apb_o;
    logic [127:0]               fc_req_i;
    logic [127:0]               fc_term_i;
    logic [127:0]               fc_ack_o;
    dmach_pkg::dmach_ibus_req_t ibus_o;
    dmach_pkg::dmach_ibus_rsp_t ibus_i = '0;
    logic                       irq_o;
    logic [6:0]                 sel = '0;
    logic                       go = 1'b0;
    logic                       term = 1'b0;
    logic                       err_arm = 1'b0;
    logic                       dir;
    logic                       rderr;
    logic [31:0]                rd, cur, base;
    logic [31:0]                wa[$];
    logic [31:0]                wd[$];
    int                         miscompares = 0, comparisons = 0, cycles = 0, wt = 0, acks = 0, target = 0;

    dmach_top dmach_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
        .fc_req_i(fc_req_i), .fc_term_i(fc_term_i), .fc_ack_o(fc_ack_o), .ibus_o(ibus_o),
        .ibus_i(ibus_i), .irq_o(irq_o));
    dmach_periph dmach_periph_i (.ack_i(fc_ack_o), .clk_i(clk_i), .sel_i(sel), .go_i(go),
        .term_i(term), .req_o(fc_req_i), .term_o(fc_term_i));

    always #50 clk_i = ~clk_i;

    // Internal bus slave: random latency; a read answer is the address scrambled
    always @(posedge clk_i)
    begin
        ibus_i.ack <= 1'b0;
        ibus_i.rdata <= ~ibus_i.rdata;
        if (ibus_o.req && !ibus_i.ack && wt == 0)
        begin
            ibus_i.ack <= 1'b1;
            ibus_i.err <= err_arm;
            ibus_i.rdata <= ibus_o.addr ^ 32'h5a5a0000;
            wt <= $urandom % 3;
            if (ibus_o.we)
            begin
                wa.push_back(ibus_o.addr);
                wd.push_back(ibus_o.wdata);
            end
        end
        else if (wt != 0)
            wt <= wt - 1;
        if (fc_ack_o[sel])
        begin
            acks <= acks + 1;
            if (acks + 1 >= target)
                go <= 1'b0;
        end
    end

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        @(posedge clk_i);
        while (!apb_o.pready)
        begin
            @(posedge clk_i);
        end
        rd = apb_o.prdata;
        rderr = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
        // Idle edge, so the next setup never reassigns psel in this time step
        @(posedge clk_i);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Runs n packets from the random slot; model of addresses and data kept here
    task automatic xfer(input int n, input logic t);
        logic [31:0] ra;
        // Park the channel first, so the slot change cannot start stray packets
        apb(1'b1, dmach_pkg::OFF_CTRL, 32'h0);
        dir = 1'($urandom % 2);
        sel = 7'($urandom);
        cur = 32'h1000 + ($urandom % 64) * 4;
        base = (32'(sel) << 9) | (32'(dir) << 8);
        apb(1'b1, dmach_pkg::OFF_CURSOR, cur);
        // A terminated run stops one packet short of its limit
        apb(1'b1, dmach_pkg::OFF_LIMIT, cur + 32'(4 * (n + int'(t))));
        apb(1'b1, dmach_pkg::OFF_DEVADDR, 32'h2000);
        apb(1'b1, dmach_pkg::OFF_CTRL, base | 32'h1);
        acks = 0;
        target <= n;
        term <= t;
        go <= 1'b1;
        while (acks < n)
        begin
            @(posedge clk_i);
        end
        term <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int p = 0; p < n; p++)
        begin
            ra = dir ? cur + 4 * p : 32'h2000;
            chk(wa.pop_front(), dir ? 32'h2000 : cur + 4 * p);
            chk(wd.pop_front(), ra ^ 32'h5a5a0000);
        end
        rchk(dmach_pkg::OFF_CTRL, t ? base : base | 32'h5);
        rchk(dmach_pkg::OFF_FLAGS, t ? 32'h0 : 32'h4);
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        rd = $urandom(47663);
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rchk(dmach_pkg::OFF_CTRL, 32'h0);
        rchk(dmach_pkg::OFF_FLAGS, 32'h0);
        rchk(dmach_pkg::OFF_MASK, 32'h0);
        apb(1'b0, 8'h44, 32'h0);
        chk(rderr, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, dmach_pkg::OFF_MASK, 32'h7);
        rchk(dmach_pkg::OFF_MASK, 32'h7);
        xfer(2, 1'b0);
        chk(irq_o, 1'b1);
        target <= 99;
        go <= 1'b1;
        repeat (6) @(posedge clk_i);
        rchk(dmach_pkg::OFF_CTRL, base | 32'h7);
        go <= 1'b0;
        rchk(dmach_pkg::OFF_FLAGS, 32'h6);
        apb(1'b1, dmach_pkg::OFF_FLAGS, 32'h4);
        rchk(dmach_pkg::OFF_FLAGS, 32'h2);
        apb(1'b1, dmach_pkg::OFF_FLAGS, 32'h0);
        rchk(dmach_pkg::OFF_FLAGS, 32'h2);
        apb(1'b1, dmach_pkg::OFF_MASK, 32'h5);
        @(posedge clk_i);
        chk(irq_o, 1'b0);
        apb(1'b1, dmach_pkg::OFF_FLAGS, 32'h7);
        xfer(1, 1'b1);
        // Requests refused with run low, then with handshake bypass
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, dmach_pkg::OFF_CURSOR, 32'h3000);
            apb(1'b1, dmach_pkg::OFF_CTRL, m ? base | 32'h80001 : base);
            go <= 1'b1;
            repeat (10) @(posedge clk_i);
            chk(32'(wa.size()), 32'h0);
            rchk(dmach_pkg::OFF_FLAGS, 32'h0);
            go <= 1'b0;
        end
        rchk(dmach_pkg::OFF_CTRL, base | 32'h80005);
        apb(1'b1, dmach_pkg::OFF_CTRL, base | 32'h1);
        err_arm <= 1'b1;
        go <= 1'b1;
        repeat (12) @(posedge clk_i);
        go <= 1'b0;
        repeat (6) @(posedge clk_i);
        err_arm <= 1'b0;
        rchk(dmach_pkg::OFF_FLAGS, 32'h1);
        apb(1'b1, dmach_pkg::OFF_MASK, 32'h1);
        @(posedge clk_i);
        chk(irq_o, 1'b1);
        apb(1'b1, dmach_pkg::OFF_MASK, 32'h0);
        @(posedge clk_i);
        chk(irq_o, 1'b0);
        give_verdict();
    end
endmodule

// ---- verilog/dmach_flag.sv ----
// Sticky interrupt flag: hardware set wins over software clear
`timescale 1ns/1ns
module dmach_flag
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);

    typedef struct packed {
        logic flag;
    } dmach_flag_st_t;

    dmach_flag_st_t s;
    dmach_flag_st_t next_s;

    always_comb
    begin
        next_s = s;
        if (set_i)
        begin
            next_s.flag = 1'b1;
        end
        else if (clr_i)
        begin
            next_s.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign flag_o = s.flag;

endmodule

// ---- verilog/dmach_pkg.sv ----
// Package: register map, field layout, states and bus carriers of the DMA channel
package dmach_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h10;
    localparam logic [7:0]  OFF_FLAGS   = 8'h14;
    localparam logic [7:0]  OFF_MASK    = 8'h18;
    localparam logic [7:0]  OFF_CURSOR  = 8'h30;
    localparam logic [7:0]  OFF_LIMIT   = 8'h34;
    localparam logic [7:0]  OFF_DEVADDR = 8'h38;

    // ------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------
    localparam int          SEL_LSB     = 9;
    localparam int          SEL_W       = 7;
    localparam int          DIR_BIT     = 8;
    localparam int          BUSY_BIT    = 5;
    localparam int          DONE_BIT    = 2;
    localparam int          REQ_BIT     = 1;
    localparam int          RUN_BIT     = 0;
    localparam int          BYPASS_BIT  = 19;
    localparam int          GO_BIT      = 24;

    // ------------------------------------------------------------
    // Flag and mask fields, reset values, step
    // ------------------------------------------------------------
    localparam int          FLAG_W      = 3;
    localparam int          FL_DONE     = 2;
    localparam int          FL_OVERRUN  = 1;
    localparam int          FL_FAULT    = 0;
    localparam int          NSLOT       = 128;
    localparam logic [31:0] RST_WORD    = 32'h0;
    localparam logic [31:0] PKT_STEP    = 32'h4;

    typedef enum logic [1:0] {
        DMACH_IDLE  = 2'b00,
        DMACH_READ  = 2'b01,
        DMACH_WRITE = 2'b11,
        DMACH_HAND  = 2'b10
    } dmach_state_t;

    typedef struct packed {
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [ADDR_W-1:0]  paddr;
        logic [31:0]        pwdata;
    } dmach_apb_req_t;

    typedef struct packed {
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } dmach_apb_rsp_t;

    typedef struct packed {
        logic               req;
        logic               we;
        logic [31:0]        addr;
        logic [31:0]        wdata;
    } dmach_ibus_req_t;

    typedef struct packed {
        logic               ack;
        logic               err;
        logic [31:0]        rdata;
    } dmach_ibus_rsp_t;

endpackage

// ---- verilog/dmach_top.sv ----
// DMA channel: control/status word, interrupt flags, packet mover, APB slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
module dmach_top
(
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    input  wire dmach_pkg::dmach_apb_req_t         apb_i,
    output dmach_pkg::dmach_apb_rsp_t              apb_o,
    input  wire logic [dmach_pkg::NSLOT-1:0]       fc_req_i,
    input  wire logic [dmach_pkg::NSLOT-1:0]       fc_term_i,
    output logic [dmach_pkg::NSLOT-1:0]            fc_ack_o,
    output dmach_pkg::dmach_ibus_req_t             ibus_o,
    input  wire dmach_pkg::dmach_ibus_rsp_t        ibus_i,
    output logic                                   irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [dmach_pkg::SEL_W-1:0]    sel;
        logic                           dir;
        logic                           run;
        logic                           bypass;
        logic                           go;
        logic [dmach_pkg::FLAG_W-1:0]   mask;
        logic [31:0]                    cursor;
        logic [31:0]                    limit;
        logic [31:0]                    devaddr;
        logic [31:0]                    data;
        dmach_pkg::dmach_state_t        st;
        dmach_pkg::dmach_ibus_req_t     bus;
        dmach_pkg::dmach_apb_rsp_t      apb;
        logic [dmach_pkg::NSLOT-1:0]    ack;
        logic                           irq;
    } dmach_st_t;

    dmach_st_t                      s;
    dmach_st_t                      next_s;
    logic [dmach_pkg::FLAG_W-1:0]   flags;
    logic [dmach_pkg::FLAG_W-1:0]   set_ev;
    logic [dmach_pkg::FLAG_W-1:0]   clr_ev;
    logic                           req_sel;
    logic                           term_sel;
    logic                           finished;
    logic                           busy;
    logic                           setup;
    logic                           wr_acc;
    logic [31:0]                    rd_word;
    logic                           rd_hit;
    logic [31:0]                    next_cursor;

    // ------------------------------------------------------------
    // Flow-control slot and status terms
    // ------------------------------------------------------------
    // Bypass blanks both request and terminate of the selected slot
    assign req_sel  = fc_req_i[s.sel] & ~s.bypass;
    assign term_sel = fc_term_i[s.sel] & ~s.bypass;
    assign finished = (s.cursor == s.limit);
    assign busy     = (s.st != dmach_pkg::DMACH_IDLE);
    assign setup    = apb_i.psel & ~apb_i.penable;
    assign wr_acc   = apb_i.psel & apb_i.penable & s.apb.pready & apb_i.pwrite;
    assign next_cursor = s.cursor + dmach_pkg::PKT_STEP;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb
    begin
        rd_word = dmach_pkg::RST_WORD;
        rd_hit  = 1'b1;
        case (apb_i.paddr)
            dmach_pkg::OFF_CTRL:
            begin
                rd_word[dmach_pkg::SEL_LSB +: dmach_pkg::SEL_W] = s.sel;
                rd_word[dmach_pkg::DIR_BIT]    = s.dir;
                rd_word[dmach_pkg::BUSY_BIT]   = busy;
                rd_word[dmach_pkg::DONE_BIT]   = s.run & ~busy;
                rd_word[dmach_pkg::REQ_BIT]    = req_sel;
                rd_word[dmach_pkg::RUN_BIT]    = s.run;
                rd_word[dmach_pkg::BYPASS_BIT] = s.bypass;
                rd_word[dmach_pkg::GO_BIT]     = s.go;
            end
            dmach_pkg::OFF_FLAGS:
            begin
                rd_word[dmach_pkg::FLAG_W-1:0] = flags;
            end
            dmach_pkg::OFF_MASK:
            begin
                rd_word[dmach_pkg::FLAG_W-1:0] = s.mask;
            end
            dmach_pkg::OFF_CURSOR:
            begin
                rd_word = s.cursor;
            end
            dmach_pkg::OFF_LIMIT:
            begin
                rd_word = s.limit;
            end
            dmach_pkg::OFF_DEVADDR:
            begin
                rd_word = s.devaddr;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        set_ev = '0;
        clr_ev = '0;
        next_s.ack = '0;

        // APB slave: no wait state, answer prepared at setup
        next_s.apb.pready = setup;
        if (setup)
        begin
            next_s.apb.prdata  = apb_i.pwrite ? dmach_pkg::RST_WORD : rd_word;
            next_s.apb.pslverr = ~rd_hit;
        end
        else if (!apb_i.psel)
        begin
            next_s.apb.prdata  = dmach_pkg::RST_WORD;
            next_s.apb.pslverr = 1'b0;
        end

        if (wr_acc)
        begin
            case (apb_i.paddr)
                dmach_pkg::OFF_CTRL:
                begin
                    next_s.sel    = apb_i.pwdata[dmach_pkg::SEL_LSB +: dmach_pkg::SEL_W];
                    next_s.dir    = apb_i.pwdata[dmach_pkg::DIR_BIT];
                    next_s.run    = apb_i.pwdata[dmach_pkg::RUN_BIT];
                    next_s.bypass = apb_i.pwdata[dmach_pkg::BYPASS_BIT];
                    next_s.go     = apb_i.pwdata[dmach_pkg::GO_BIT];
                end
                dmach_pkg::OFF_FLAGS:
                begin
                    clr_ev = apb_i.pwdata[dmach_pkg::FLAG_W-1:0];
                end
                dmach_pkg::OFF_MASK:
                begin
                    next_s.mask = apb_i.pwdata[dmach_pkg::FLAG_W-1:0];
                end
                dmach_pkg::OFF_CURSOR:
                begin
                    next_s.cursor = apb_i.pwdata;
                end
                dmach_pkg::OFF_LIMIT:
                begin
                    next_s.limit = apb_i.pwdata;
                end
                dmach_pkg::OFF_DEVADDR:
                begin
                    next_s.devaddr = apb_i.pwdata;
                end
                default:
                begin
                    next_s.mask = s.mask;
                end
            endcase
        end

        // Packet mover
        case (s.st)
            dmach_pkg::DMACH_IDLE:
            begin
                if (!s.bypass)
                begin
                    if (s.run && req_sel)
                    begin
                        if (finished)
                        begin
                            set_ev[dmach_pkg::FL_OVERRUN] = 1'b1;
                        end
                        else
                        begin
                            next_s.st = dmach_pkg::DMACH_READ;
                        end
                    end
                end
                else if (s.go)
                begin
                    next_s.go = 1'b0;
                    if (!finished)
                    begin
                        next_s.st = dmach_pkg::DMACH_READ;
                    end
                end
                if (next_s.st == dmach_pkg::DMACH_READ)
                begin
                    next_s.bus.req  = 1'b1;
                    next_s.bus.we   = 1'b0;
                    next_s.bus.addr = s.dir ? s.cursor : s.devaddr;
                end
            end
            dmach_pkg::DMACH_READ:
            begin
                if (ibus_i.ack)
                begin
                    if (ibus_i.err)
                    begin
                        set_ev[dmach_pkg::FL_FAULT] = 1'b1;
                        next_s.bus.req = 1'b0;
                        next_s.st      = dmach_pkg::DMACH_IDLE;
                    end
                    else
                    begin
                        next_s.bus.we    = 1'b1;
                        next_s.bus.wdata = ibus_i.rdata;
                        next_s.bus.addr  = s.dir ? s.devaddr : s.cursor;
                        next_s.st        = dmach_pkg::DMACH_WRITE;
                    end
                end
            end
            dmach_pkg::DMACH_WRITE:
            begin
                if (ibus_i.ack)
                begin
                    next_s.bus.req = 1'b0;
                    next_s.bus.we  = 1'b0;
                    if (ibus_i.err)
                    begin
                        set_ev[dmach_pkg::FL_FAULT] = 1'b1;
                        next_s.st = dmach_pkg::DMACH_IDLE;
                    end
                    else
                    begin
                        next_s.cursor = next_cursor;
                        if (next_cursor == s.limit)
                        begin
                            set_ev[dmach_pkg::FL_DONE] = 1'b1;
                        end
                        if (!s.bypass)
                        begin
                            next_s.st = dmach_pkg::DMACH_HAND;
                        end
                        else if (next_cursor != s.limit)
                        begin
                            // Firmware mode runs on to the limit
                            next_s.bus.req  = 1'b1;
                            next_s.bus.addr = s.dir ? next_cursor : s.devaddr;
                            next_s.st       = dmach_pkg::DMACH_READ;
                        end
                        else
                        begin
                            next_s.st = dmach_pkg::DMACH_IDLE;
                        end
                    end
                end
            end
            dmach_pkg::DMACH_HAND:
            begin
                // One-cycle acknowledge to the selected master
                next_s.ack[s.sel] = 1'b1;
                next_s.st         = dmach_pkg::DMACH_IDLE;
                if (term_sel)
                begin
                    // Early stop by peripheral: channel halts, no completion
                    next_s.run = 1'b0;
                end
            end
            default:
            begin
                next_s.st      = dmach_pkg::DMACH_IDLE;
                next_s.bus.req = 1'b0;
            end
        endcase

        // Lags the flag flops by one cycle so irq_o stays a plain flop
        next_s.irq = |(flags & s.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < dmach_pkg::FLAG_W; gi++)
        begin : g_flag
            dmach_flag u_flag
            (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .set_i   (set_ev[gi]),
                .clr_i   (clr_ev[gi]),
                .flag_o  (flags[gi])
            );
        end
    endgenerate

    assign apb_o    = s.apb;
    assign ibus_o   = s.bus;
    assign fc_ack_o = s.ack;
    assign irq_o    = s.irq;

endmodule
